/* File: ccs_pkg.sv */
// Constants, codes and carrier types for clock source select and HF oscillator control
// Functional notes
// RL1: USB source 000 HF osc, 001 HF osc/8, 110 LF osc; 111 reserved.
// RL2: USB source 010 to 101 give external oscillator divided by 1, 2, 3, 4.
// RL3: Clock-select bit 7 always reads zero and ignores writes.
// RL4: Bit 3 picks crossbar clock out: raw system clock or port-synchronized copy.
// RL5: System source 000 scaled HF osc, 001 external, 100 scaled LF osc.
// RL6: System source 010 is HF osc/2; 011 is HF osc undivided.
// RL7: Any reset clears clock-select to zero, system clock from HF oscillator.
// RL8: HF path to system clock is fixed divide-by-4, then divide by 1/2/4/8.
// RL9: After reset the programmable divider is divide-by-eight, 1.5 MHz.
// RL10: Writing suspend bit stops HF oscillator; HF-fed core and peripheral clocks stop.
// RL11: Suspend ends on port 0 match, port 1 match, third timer overflow, USB resume.
// RL12: Wake restarts oscillator, core and peripherals whether or not it interrupts.
// RL13: Core resumes with the instruction after the suspend write.
// RL14: Seven-bit trim sets period monotonically; zeros fastest, ones slowest.
// RL15: Reset loads the per-part factory trim giving 48 MHz.
// RL16: Calibration bit 7 reads zero and ignores writes.
// RL17: Software switches system clock only to an enabled, running source.
// RL18: Software sets USB clock to 48 MHz full speed or 6 MHz low speed.
// RL19: Divider code 00, 01, 10, 11 divides by 8, 4, 2, 1.
// RL20: Source switching produces no runt pulse on system or USB clock.
package ccs_pkg;

   // ----------------------------------------------------------------
   // Register addresses and layout
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CLK_SEL = 8'hA9;
   localparam logic [7:0] ADDR_OSC_CTL = 8'hB2;
   localparam logic [7:0] ADDR_OSC_CAL = 8'hB3;
   localparam int USB_SEL_LSB = 4;
   localparam int OUT_SEL_BIT = 3;
   localparam int SYS_SEL_LSB = 0;
   localparam int OSC_EN_BIT = 7;
   localparam int OSC_RDY_BIT = 6;
   localparam int SUSPEND_BIT = 5;
   localparam int HF_DIV_LSB = 0;
   localparam logic [6:0] CLK_SEL_RST = 7'h00;
   localparam logic OSC_EN_RST = 1'b1;
   localparam logic SUSPEND_RST = 1'b0;
   localparam logic [1:0] HF_DIV_RST = 2'h0;
   localparam logic [7:0] RD_NONE = 8'h00;

   // ----------------------------------------------------------------
   // Divider settings (count limits, value minus one)
   // ----------------------------------------------------------------
   localparam logic [2:0] HF_PRE_M1 = 3'h3;
   localparam logic [2:0] HF_DIV2_M1 = 3'h1;
   localparam logic [2:0] HF_DIV8_M1 = 3'h7;
   localparam logic [2:0] EXT_CODE_BASE = 3'h2;

   // ----------------------------------------------------------------
   // Source codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SYS_HF_SCALED = 3'b000, SYS_EXT = 3'b001, SYS_HF_DIV2 = 3'b010, SYS_HF_FULL = 3'b011,
      SYS_LF = 3'b100, SYS_RSV5 = 3'b101, SYS_RSV6 = 3'b110, SYS_RSV7 = 3'b111
   } ccs_sys_sel_e;
   typedef enum logic [2:0] {
      USB_HF = 3'b000, USB_HF_DIV8 = 3'b001, USB_EXT_DIV1 = 3'b010, USB_EXT_DIV2 = 3'b011,
      USB_EXT_DIV3 = 3'b100, USB_EXT_DIV4 = 3'b101, USB_LF = 3'b110, USB_RSV = 3'b111
   } ccs_usb_sel_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ccs_sfr_req_s;
   typedef struct packed {
      logic hf;
      logic lf;
      logic ext;
   } ccs_osc_ticks_s;
   typedef struct packed {
      logic port0_match;
      logic port1_match;
      logic third_timer_ovf;
      logic usb_resume;
   } ccs_wake_s;
   typedef struct packed {
      logic [6:0] clk_sel;
      logic osc_en;
      logic suspend;
      logic [1:0] hf_div;
      logic [6:0] trim;
      logic [7:0] rdata;
      logic sys_lvl;
      logic xbar_sync;
      logic xbar_out;
   } ccs_state_s;

   // Divider code to count limit: 00 /8, 01 /4, 10 /2, 11 /1
   function automatic logic [2:0] hf_div_m1(input logic [1:0] code);
      logic [2:0] m1;
      m1 = 3'h7;
      case (code)
         2'h0: m1 = 3'h7;
         2'h1: m1 = 3'h3;
         2'h2: m1 = 3'h1;
         default: m1 = 3'h0;
      endcase
      return m1;
   endfunction

endpackage

/* File: ccs_tick_div.sv */
// Tick divider: passes every Nth oscillator tick, N = div_m1 + 1
module ccs_tick_div #(
   parameter int W = 3
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clr,
   input wire logic tick_in,
   input wire logic [W-1:0] div_m1,
   output logic tick_out
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } ccs_div_state_s;

   ccs_div_state_s st_r;
   ccs_div_state_s st_nxt;

   // Output tick closes a whole divided period
   assign tick_out = tick_in && (st_r.cnt == div_m1);

   // Count input ticks; clear restarts the period
   always_comb begin
      st_nxt = st_r;
      if (srst || clr) begin
         st_nxt.cnt = '0;
      end else if (tick_in) begin
         st_nxt.cnt = (st_r.cnt == div_m1) ? '0 : st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   a_div_period: assert property (@(posedge sys_clk) disable iff (srst)
      tick_out |-> st_r.cnt == div_m1)
      else $error("divider tick outside period end");

endmodule

/* File: ccs_glitch_sel.sv */
// Glitch-free selector: adopts a new source code only at the end of a whole output period or while the old source is idle
module ccs_glitch_sel #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_SEL = '0
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [W-1:0] want_sel,
   input wire logic old_tick,
   input wire logic old_idle,
   output logic [W-1:0] act_sel,
   output logic switch_now
);

   typedef struct packed {
      logic [W-1:0] act;
   } ccs_gsel_state_s;

   ccs_gsel_state_s st_r;
   ccs_gsel_state_s st_nxt;

   // Switch only after the old source closed its period or is not running
   assign switch_now = (want_sel != st_r.act) && (old_tick || old_idle); // [RL20]
   assign act_sel = st_r.act;

   always_comb begin
      st_nxt = st_r;
      if (srst) begin
         st_nxt.act = RST_SEL;
      end else if (switch_now) begin
         st_nxt.act = want_sel;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   a_switch_boundary: assert property (@(posedge sys_clk) disable iff (srst) // [RL20]
      !$stable(st_r.act) && !$past(srst) |-> $past(old_tick) || $past(old_idle))
      else $error("clock source switched mid period");

endmodule

/* File: ccs_clock_ctrl.sv */
// Clock source select, HF oscillator control, calibration and suspend
module ccs_clock_ctrl (
   input wire logic sys_clk,
   input wire logic srst,
   input wire ccs_pkg::ccs_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic [6:0] factory_trim,
   input wire logic hf_osc_ready,
   input wire ccs_pkg::ccs_osc_ticks_s osc_ticks,
   input wire ccs_pkg::ccs_wake_s wake,
   output logic hf_osc_run,
   output logic [6:0] hf_osc_trim,
   output logic sys_clk_tick,
   output logic usb_clk_tick,
   output logic core_clk_hold,
   output logic xbar_clk_out
);

   ccs_pkg::ccs_state_s st_r;
   ccs_pkg::ccs_state_s st_nxt;
   logic wr_sel;
   logic wr_ctl;
   logic wr_cal;
   logic wake_any;
   logic hf_g;
   logic hf_q;
   logic sys_prog;
   logic hf_div2;
   logic hf_div8;
   logic ext_n;
   logic sys_switch;
   logic usb_switch;
   logic sys_idle;
   logic usb_idle;
   logic sys_on_hf;
   logic [2:0] want_sys;
   logic [2:0] want_usb;
   logic [2:0] act_sys;
   logic [2:0] act_usb;
   logic [2:0] ext_m1;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   assign wr_sel = sfr_req.wr && (sfr_req.addr == ccs_pkg::ADDR_CLK_SEL);
   assign wr_ctl = sfr_req.wr && (sfr_req.addr == ccs_pkg::ADDR_OSC_CTL);
   assign wr_cal = sfr_req.wr && (sfr_req.addr == ccs_pkg::ADDR_OSC_CAL);
   assign want_sys = st_r.clk_sel[ccs_pkg::SYS_SEL_LSB +: 3];
   assign want_usb = st_r.clk_sel[ccs_pkg::USB_SEL_LSB +: 3];

   // Any of the four wake events ends suspend
   assign wake_any = wake.port0_match || wake.port1_match
                     || wake.third_timer_ovf || wake.usb_resume; // [RL11]

   // ----------------------------------------------------------------
   // Oscillator gating and divider chain
   // ----------------------------------------------------------------
   // Suspended or disabled oscillator delivers no ticks
   assign hf_osc_run = st_r.osc_en && !st_r.suspend; // [RL10] [RL12]
   assign hf_g = osc_ticks.hf && hf_osc_run;
   assign hf_osc_trim = st_r.trim; // [RL14]

   // Fixed divide-by-4 stage ahead of the programmable divider
   ccs_tick_div #(.W(3)) u_hf_pre (
      .sys_clk(sys_clk),
      .srst(srst),
      .clr(sys_switch),
      .tick_in(hf_g),
      .div_m1(ccs_pkg::HF_PRE_M1), // [RL8]
      .tick_out(hf_q)
   );

   // Programmable divide by 8, 4, 2 or 1
   ccs_tick_div #(.W(3)) u_hf_prog (
      .sys_clk(sys_clk),
      .srst(srst),
      .clr(sys_switch),
      .tick_in(hf_q),
      .div_m1(ccs_pkg::hf_div_m1(st_r.hf_div)), // [RL8] [RL19]
      .tick_out(sys_prog)
   );

   // HF divided by two for the system clock
   ccs_tick_div #(.W(3)) u_hf_div2 (
      .sys_clk(sys_clk),
      .srst(srst),
      .clr(sys_switch),
      .tick_in(hf_g),
      .div_m1(ccs_pkg::HF_DIV2_M1), // [RL6]
      .tick_out(hf_div2)
   );

   // HF divided by eight for the USB clock
   ccs_tick_div #(.W(3)) u_hf_div8 (
      .sys_clk(sys_clk),
      .srst(srst),
      .clr(usb_switch),
      .tick_in(hf_g),
      .div_m1(ccs_pkg::HF_DIV8_M1), // [RL1]
      .tick_out(hf_div8)
   );

   // External oscillator divided by 1 to 4 from the USB code
   assign ext_m1 = act_usb - ccs_pkg::EXT_CODE_BASE; // [RL2]
   ccs_tick_div #(.W(3)) u_ext_div (
      .sys_clk(sys_clk),
      .srst(srst),
      .clr(usb_switch),
      .tick_in(osc_ticks.ext),
      .div_m1(ext_m1),
      .tick_out(ext_n)
   );

   // ----------------------------------------------------------------
   // Glitch-free source selection
   // ----------------------------------------------------------------
   assign sys_idle = (act_sys > 3'(ccs_pkg::SYS_LF)) || (sys_on_hf && !hf_osc_run);
   assign usb_idle = (act_usb == 3'(ccs_pkg::USB_RSV));

   ccs_glitch_sel #(.W(3), .RST_SEL(3'(ccs_pkg::SYS_HF_SCALED))) u_sys_sel (
      .sys_clk(sys_clk),
      .srst(srst),
      .want_sel(want_sys),
      .old_tick(sys_clk_tick),
      .old_idle(sys_idle),
      .act_sel(act_sys),
      .switch_now(sys_switch)
   );

   ccs_glitch_sel #(.W(3), .RST_SEL(3'(ccs_pkg::USB_HF))) u_usb_sel (
      .sys_clk(sys_clk),
      .srst(srst),
      .want_sel(want_usb),
      .old_tick(usb_clk_tick),
      .old_idle(usb_idle),
      .act_sel(act_usb),
      .switch_now(usb_switch)
   );

   // System clock source multiplexer
   always_comb begin
      sys_clk_tick = 1'b0;
      case (ccs_pkg::ccs_sys_sel_e'(act_sys))
         ccs_pkg::SYS_HF_SCALED: sys_clk_tick = sys_prog; // [RL5]
         ccs_pkg::SYS_EXT: sys_clk_tick = osc_ticks.ext; // [RL5]
         ccs_pkg::SYS_HF_DIV2: sys_clk_tick = hf_div2; // [RL6]
         ccs_pkg::SYS_HF_FULL: sys_clk_tick = hf_g; // [RL6]
         ccs_pkg::SYS_LF: sys_clk_tick = osc_ticks.lf; // [RL5]
         default: sys_clk_tick = 1'b0;
      endcase
   end

   // USB clock source multiplexer
   always_comb begin
      usb_clk_tick = 1'b0;
      case (ccs_pkg::ccs_usb_sel_e'(act_usb))
         ccs_pkg::USB_HF: usb_clk_tick = hf_g; // [RL1]
         ccs_pkg::USB_HF_DIV8: usb_clk_tick = hf_div8; // [RL1]
         ccs_pkg::USB_EXT_DIV1: usb_clk_tick = ext_n; // [RL2]
         ccs_pkg::USB_EXT_DIV2: usb_clk_tick = ext_n; // [RL2]
         ccs_pkg::USB_EXT_DIV3: usb_clk_tick = ext_n; // [RL2]
         ccs_pkg::USB_EXT_DIV4: usb_clk_tick = ext_n; // [RL2]
         ccs_pkg::USB_LF: usb_clk_tick = osc_ticks.lf; // [RL1]
         default: usb_clk_tick = 1'b0; // [RL1]
      endcase
   end

   // Core held while its clock source is a suspended HF oscillator
   assign sys_on_hf = (act_sys == 3'(ccs_pkg::SYS_HF_SCALED)) || (act_sys == 3'(ccs_pkg::SYS_HF_DIV2))
                      || (act_sys == 3'(ccs_pkg::SYS_HF_FULL));
   assign core_clk_hold = st_r.suspend && sys_on_hf; // [RL10] [RL13]

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      if (srst) begin
         st_nxt.clk_sel = ccs_pkg::CLK_SEL_RST; // [RL7]
         st_nxt.osc_en = ccs_pkg::OSC_EN_RST;
         st_nxt.suspend = ccs_pkg::SUSPEND_RST;
         st_nxt.hf_div = ccs_pkg::HF_DIV_RST; // [RL9]
         st_nxt.trim = factory_trim; // [RL15]
         st_nxt.rdata = ccs_pkg::RD_NONE;
         st_nxt.sys_lvl = 1'b0;
         st_nxt.xbar_sync = 1'b0;
         st_nxt.xbar_out = 1'b0;
      end else begin
         // Bit 7 of both select and trim is dropped on write
         if (wr_sel) begin
            st_nxt.clk_sel = sfr_req.wdata[6:0]; // [RL3]
         end
         if (wr_cal) begin
            st_nxt.trim = sfr_req.wdata[6:0]; // [RL16]
         end
         if (wr_ctl) begin
            st_nxt.osc_en = sfr_req.wdata[ccs_pkg::OSC_EN_BIT];
            st_nxt.hf_div = sfr_req.wdata[ccs_pkg::HF_DIV_LSB +: 2];
            st_nxt.suspend = sfr_req.wdata[ccs_pkg::SUSPEND_BIT]; // [RL10]
         end
         // A wake event in the same cycle as a suspend write wins
         if (wake_any) begin
            st_nxt.suspend = 1'b0; // [RL11] [RL12]
         end
         // Read data registered one cycle after the strobe
         if (sfr_req.rd) begin
            case (sfr_req.addr)
               ccs_pkg::ADDR_CLK_SEL: st_nxt.rdata = {1'b0, st_r.clk_sel}; // [RL3]
               ccs_pkg::ADDR_OSC_CTL: st_nxt.rdata = {st_r.osc_en, hf_osc_ready, st_r.suspend,
                                                      3'h0, st_r.hf_div};
               ccs_pkg::ADDR_OSC_CAL: st_nxt.rdata = {1'b0, st_r.trim}; // [RL16]
               default: st_nxt.rdata = ccs_pkg::RD_NONE;
            endcase
         end
         // System clock level and its crossbar copies
         if (sys_clk_tick) begin
            st_nxt.sys_lvl = !st_r.sys_lvl;
         end
         st_nxt.xbar_sync = st_r.sys_lvl;
         st_nxt.xbar_out = st_r.clk_sel[ccs_pkg::OUT_SEL_BIT] ? st_r.xbar_sync : st_r.sys_lvl; // [RL4]
      end
   end

   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign sfr_rdata = st_r.rdata;
   assign xbar_clk_out = st_r.xbar_out;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_suspend_write;
      wr_ctl && sfr_req.wdata[ccs_pkg::SUSPEND_BIT] && !wake_any;
   endsequence
   sequence s_halted;
      !hf_osc_run && st_r.suspend;
   endsequence

   a_sel_reset: assert property (disable iff (1'b0) srst |=> st_r.clk_sel == 7'h00 && act_sys == 3'h0) // [RL7]
      else $error("clock select not cleared by reset");
   a_div_reset: assert property (disable iff (1'b0) srst |=> st_r.hf_div == 2'h0) // [RL9]
      else $error("divider not at divide by eight after reset");
   a_trim_reset: assert property (disable iff (1'b0) srst |=> hf_osc_trim == $past(factory_trim)) // [RL15]
      else $error("trim not loaded from factory value");
   a_sel_read_top: assert property (sfr_req.rd && sfr_req.addr == ccs_pkg::ADDR_CLK_SEL |=> !sfr_rdata[7]) // [RL3]
      else $error("select bit 7 read nonzero");
   a_cal_read_top: assert property (sfr_req.rd && sfr_req.addr == ccs_pkg::ADDR_OSC_CAL // [RL16]
      |=> sfr_rdata == {1'b0, $past(hf_osc_trim)})
      else $error("calibration readback wrong");
   a_suspend_halts: assert property (s_suspend_write |=> s_halted) // [RL10]
      else $error("oscillator not halted by suspend");
   a_wake_resumes: assert property (st_r.suspend && wake_any |=> hf_osc_run == st_r.osc_en && !core_clk_hold) // [RL11]
      else $error("wake event did not end suspend");
   a_core_hold: assert property ((s_halted and sys_on_hf) |-> core_clk_hold && !sys_clk_tick) // [RL13]
      else $error("core clock ran during suspend");
   a_usb_reserved: assert property (act_usb == 3'h7 |-> !usb_clk_tick) // [RL1]
      else $error("reserved USB source produced a tick");
   a_sys_full: assert property (act_sys == 3'h3 |-> sys_clk_tick == hf_g) // [RL6]
      else $error("undivided HF source mismatch");
   a_xbar_raw: assert property (!st_r.clk_sel[ccs_pkg::OUT_SEL_BIT] |=> xbar_clk_out == $past(st_r.sys_lvl)) // [RL4]
      else $error("crossbar raw clock mismatch");
   a_xbar_sync: assert property (st_r.clk_sel[ccs_pkg::OUT_SEL_BIT] // [RL4]
      |=> xbar_clk_out == $past(st_r.xbar_sync))
      else $error("crossbar synchronized clock mismatch");
   a_reset_osc_on: assert property (disable iff (1'b0) srst |=> hf_osc_run && !core_clk_hold) // [RL7]
      else $error("oscillator not running after reset");

   // Register writes land in the next cycle, unused bits dropped
   a_sel_write: assert property (wr_sel |=> st_r.clk_sel == $past(sfr_req.wdata[6:0])) // [RL3]
      else $error("select write not taken");
   a_cal_write: assert property (wr_cal |=> hf_osc_trim == $past(sfr_req.wdata[6:0])) // [RL14]
      else $error("trim write not taken");
   a_ctl_read: assert property (sfr_req.rd && sfr_req.addr == ccs_pkg::ADDR_OSC_CTL // [RL10]
      |=> sfr_rdata[4:2] == 3'h0 && sfr_rdata[5] == $past(st_r.suspend))
      else $error("control readback wrong");

   // ----------------------------------------------------------------
   // Source multiplexer checks
   // ----------------------------------------------------------------
   a_hf_gate: assert property (!hf_osc_run |-> !hf_g) // [RL10]
      else $error("HF tick passed while oscillator stopped");
   a_hold_ext: assert property (!sys_on_hf |-> !core_clk_hold) // [RL10]
      else $error("core held on a non HF source");
   a_scaled_sub: assert property (act_sys == 3'h0 && sys_clk_tick |-> hf_q) // [RL8]
      else $error("scaled system tick off the prescaler grid");
   a_sys_div2: assert property (act_sys == 3'h2 && sys_clk_tick |-> hf_g) // [RL6]
      else $error("halved HF tick without an HF tick");
   a_sys_ext: assert property (act_sys == 3'h1 |-> sys_clk_tick == osc_ticks.ext) // [RL5]
      else $error("external system source mismatch");
   a_sys_lf: assert property (act_sys == 3'h4 |-> sys_clk_tick == osc_ticks.lf) // [RL5]
      else $error("LF system source mismatch");
   a_sys_rsv: assert property (act_sys > 3'h4 |-> !sys_clk_tick) // [RL5]
      else $error("reserved system source produced a tick");
   a_usb_hf: assert property (act_usb == 3'h0 |-> usb_clk_tick == hf_g) // [RL1]
      else $error("undivided HF USB source mismatch");
   a_usb_div8: assert property (act_usb == 3'h1 && usb_clk_tick |-> hf_g) // [RL1]
      else $error("HF by eight USB tick without an HF tick");
   a_usb_ext_only: assert property ((act_usb inside {3'h2, 3'h3, 3'h4, 3'h5}) && usb_clk_tick |-> osc_ticks.ext) // [RL2]
      else $error("external USB tick without an external tick");
   a_usb_lf: assert property (act_usb == 3'h6 |-> usb_clk_tick == osc_ticks.lf) // [RL1]
      else $error("LF USB source mismatch");

endmodule

/* File: tb_top.sv */
// Self-checking testbench for the clock source select and HF oscillator control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   ccs_pkg::ccs_sfr_req_s sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic [6:0] factory_trim = 7'h00;
   logic hf_osc_ready = 1'b0;
   ccs_pkg::ccs_osc_ticks_s osc_ticks = '0;
   ccs_pkg::ccs_wake_s wake = '0;
   logic hf_osc_run;
   logic [6:0] hf_osc_trim;
   logic sys_clk_tick;
   logic usb_clk_tick;
   logic core_clk_hold;
   logic xbar_clk_out;
   int n_fail = 0;
   int checked = 0;
   integer seed = 32'hC466;
   int cyc = 0;

   ccs_clock_ctrl ccs_clock_ctrl_i (
      .sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .factory_trim(factory_trim), .hf_osc_ready(hf_osc_ready), .osc_ticks(osc_ticks),
      .wake(wake), .hf_osc_run(hf_osc_run), .hf_osc_trim(hf_osc_trim),
      .sys_clk_tick(sys_clk_tick), .usb_clk_tick(usb_clk_tick),
      .core_clk_hold(core_clk_hold), .xbar_clk_out(xbar_clk_out)
   );

   // Clock at 100 MHz
   always #5 sys_clk = ~sys_clk;

   // Oscillator ticks: HF every cycle, external every 2nd, LF every 4th, so sources tell apart
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      osc_ticks <= '{hf: 1'b1, lf: (cyc % 4 == 1), ext: (cyc % 2 == 0)};
   end

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("Comparisons: %0d, mismatches: %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // Register bus cycles: strobe held for one sampling edge
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge sys_clk);
      sfr_req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge sys_clk);
      sfr_req <= '0;
      @(negedge sys_clk);
      chk({8'h00, sfr_rdata}, {8'h00, e});
   endtask

   // Counts ticks and crossbar toggles over a window that every period divides
   task automatic measure(output int ns, output int nu, output int nt);
      logic last;
      ns = 0;
      nu = 0;
      nt = 0;
      @(negedge sys_clk);
      last = xbar_clk_out;
      repeat (384) begin
         @(negedge sys_clk);
         if (sys_clk_tick === 1'b1) ns++;
         if (usb_clk_tick === 1'b1) nu++;
         if (xbar_clk_out !== last) nt++;
         last = xbar_clk_out;
      end
   endtask

   // ----------------------------------------------------------------
   // Expected counts per 384-cycle window
   // ----------------------------------------------------------------
   function automatic int exp_sys(input logic [2:0] c, input logic [1:0] d);
      case (c)
         3'h0: return 384 / (4 * (8 >> d));
         3'h1: return 192;
         3'h2: return 192;
         3'h3: return 384;
         3'h4: return 96;
         default: return 0;
      endcase
   endfunction

   function automatic int exp_usb(input logic [2:0] c);
      case (c)
         3'h0: return 384;
         3'h1: return 48;
         3'h2: return 192;
         3'h3: return 96;
         3'h4: return 64;
         3'h5: return 48;
         3'h6: return 96;
         default: return 0;
      endcase
   endfunction

   // Watchdog that cuts a hang short
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int ns;
      int nu;
      int nt;
      logic [7:0] d;
      logic [7:0] v;
      logic [2:0] usb;
      logic [1:0] dv;
      factory_trim <= 7'($random(seed));
      hf_osc_ready <= 1'($random(seed));
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      // Reset values and reset clocking
      rd(ccs_pkg::ADDR_CLK_SEL, 8'h00);
      rd(ccs_pkg::ADDR_OSC_CAL, {1'b0, factory_trim});
      rd(ccs_pkg::ADDR_OSC_CTL, {1'b1, hf_osc_ready, 6'h00});
      chk({9'h000, hf_osc_trim}, {9'h000, factory_trim});
      measure(ns, nu, nt);
      chk(16'(ns), 16'(12));
      // Calibration writes, corners first, then random
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h80 : 8'($random(seed));
         wr(ccs_pkg::ADDR_OSC_CAL, d);
         rd(ccs_pkg::ADDR_OSC_CAL, {1'b0, d[6:0]});
         chk({9'h000, hf_osc_trim}, {9'h000, d[6:0]});
      end
      // Unmapped place reads zero and leaves the select untouched
      wr(8'hAA, 8'h55);
      rd(8'hAA, 8'h00);
      rd(ccs_pkg::ADDR_CLK_SEL, 8'h00);
      // Every system and USB source code with random divider and crossbar mode
      for (int i = 0; i < 8; i++) begin
         dv = 2'($random(seed));
         usb = 3'(7 - i);
         v = {1'b1, usb, 1'($random(seed)), 3'(i)};
         wr(ccs_pkg::ADDR_OSC_CTL, {3'b100, 3'b111, dv});
         rd(ccs_pkg::ADDR_OSC_CTL, {1'b1, hf_osc_ready, 4'h0, dv});
         wr(ccs_pkg::ADDR_CLK_SEL, v);
         rd(ccs_pkg::ADDR_CLK_SEL, {1'b0, v[6:0]});
         repeat (80) @(posedge sys_clk);
         measure(ns, nu, nt);
         chk(16'(ns), 16'(exp_sys(3'(i), dv)));
         chk(16'(nu), 16'(exp_usb(usb)));
         chk(16'(nt), 16'(exp_sys(3'(i), dv)));
      end
      // Suspend from the HF source, woken by each event in turn
      wr(ccs_pkg::ADDR_CLK_SEL, 8'h00);
      wr(ccs_pkg::ADDR_OSC_CTL, 8'h83);
      repeat (80) @(posedge sys_clk);
      for (int k = 0; k < 4; k++) begin
         wr(ccs_pkg::ADDR_OSC_CTL, 8'hA3);
         @(negedge sys_clk);
         chk({15'h0000, hf_osc_run}, 16'h0000);
         chk({15'h0000, core_clk_hold}, 16'h0001);
         rd(ccs_pkg::ADDR_OSC_CTL, {1'b1, hf_osc_ready, 1'b1, 3'h0, 2'h3});
         measure(ns, nu, nt);
         chk(16'(ns), 16'h0000);
         @(posedge sys_clk);
         wake <= 4'(1 << k);
         @(posedge sys_clk);
         wake <= '0;
         @(negedge sys_clk);
         chk({15'h0000, hf_osc_run}, 16'h0001);
         chk({15'h0000, core_clk_hold}, 16'h0000);
         repeat (80) @(posedge sys_clk);
         measure(ns, nu, nt);
         chk(16'(ns), 16'(96));
      end
      // Suspend while running from the external source keeps the core clocked
      wr(ccs_pkg::ADDR_CLK_SEL, 8'h01);
      repeat (80) @(posedge sys_clk);
      wr(ccs_pkg::ADDR_OSC_CTL, 8'hA3);
      @(negedge sys_clk);
      chk({15'h0000, core_clk_hold}, 16'h0000);
      measure(ns, nu, nt);
      chk(16'(ns), 16'(192));
      @(posedge sys_clk);
      wake <= 4'h1;
      @(posedge sys_clk);
      wake <= '0;
      // Second reset in mid-run restores every register
      wr(ccs_pkg::ADDR_CLK_SEL, 8'h7B);
      wr(ccs_pkg::ADDR_OSC_CAL, 8'h12);
      @(posedge sys_clk);
      srst <= 1'b1;
      @(posedge sys_clk);
      srst <= 1'b0;
      rd(ccs_pkg::ADDR_CLK_SEL, 8'h00);
      rd(ccs_pkg::ADDR_OSC_CAL, {1'b0, factory_trim});
      rd(ccs_pkg::ADDR_OSC_CTL, {1'b1, hf_osc_ready, 6'h00});
      close_out();
   end
endmodule
